// ===== core/fbx_pkg.sv
// Shared constants, types and decode helpers for the flag and memory core
package fbx_pkg;

    localparam int APB_AW = 8;
    localparam int DMEM_AW = 16;
    localparam int GPR_N = 32;

    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_ABS_ADDR = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_GPR_SEL = 8'h0c;
    localparam logic [7:0] OFS_GPR_DATA = 8'h10;
    localparam logic [7:0] OFS_INFO = 8'h14;

    localparam int SB_C = 0;
    localparam int SB_Z = 1;
    localparam int SB_N = 2;
    localparam int SB_V = 3;
    localparam int SB_S = 4;
    localparam int SB_H = 5;
    localparam int SB_T = 6;
    localparam int SB_I = 7;
    localparam int STATUS_BUSY_BIT = 8;
    localparam int INFO_ILLEGAL_BIT = 0;

    localparam logic [7:0] STATUS_REGISTER_RST = 8'h00;
    localparam logic [7:0] GPR_RST = 8'h00;
    localparam logic [15:0] ABS_ADDR_RST = 16'h0000;

    localparam logic [4:0] PTR_X = 5'h1a;
    localparam logic [4:0] PTR_Y = 5'h1c;
    localparam logic [4:0] PTR_Z = 5'h1e;

    typedef enum logic [5:0] {
        OP_NOP = 6'h00,
        OP_ARITH_RIGHT_SHIFT = 6'h01,
        OP_NIBBLE_SWAP = 6'h02,
        OP_STATUS_BIT_RAISE = 6'h03,
        OP_STATUS_BIT_LOWER = 6'h04,
        OP_BIT_TO_TRANSFER_FLAG = 6'h05,
        OP_TRANSFER_FLAG_TO_BIT = 6'h06,
        OP_CARRY_RAISE = 6'h07,
        OP_CARRY_LOWER = 6'h08,
        OP_NEGATIVE_RAISE = 6'h09,
        OP_NEGATIVE_LOWER = 6'h0a,
        OP_ZERO_RAISE = 6'h0b,
        OP_ZERO_LOWER = 6'h0c,
        OP_IRQ_GLOBAL_ON = 6'h0d,
        OP_IRQ_GLOBAL_OFF = 6'h0e,
        OP_SIGN_FLAG_RAISE = 6'h0f,
        OP_SIGN_FLAG_LOWER = 6'h10,
        OP_OVERFLOW_RAISE = 6'h11,
        OP_OVERFLOW_LOWER = 6'h12,
        OP_TRANSFER_FLAG_RAISE = 6'h13,
        OP_TRANSFER_FLAG_LOWER = 6'h14,
        OP_HALF_CARRY_RAISE = 6'h15,
        OP_HALF_CARRY_LOWER = 6'h16,
        OP_REGISTER_COPY = 6'h17,
        OP_REGISTER_PAIR_COPY = 6'h18,
        OP_IMMEDIATE_LOAD = 6'h19,
        OP_MEM_READ_X = 6'h1a,
        OP_MEM_READ_X_INC = 6'h1b,
        OP_MEM_READ_X_DEC = 6'h1c,
        OP_MEM_READ_Y = 6'h1d,
        OP_MEM_READ_Y_INC = 6'h1e,
        OP_MEM_READ_Y_DEC = 6'h1f,
        OP_MEM_READ_OFFSET_Y = 6'h20,
        OP_MEM_READ_Z = 6'h21,
        OP_MEM_READ_Z_INC = 6'h22,
        OP_MEM_READ_Z_DEC = 6'h23,
        OP_MEM_READ_OFFSET_Z = 6'h24,
        OP_MEM_READ_ABSOLUTE = 6'h25,
        OP_MEM_WRITE_X = 6'h26,
        OP_MEM_WRITE_X_INC = 6'h27,
        OP_MEM_WRITE_X_DEC = 6'h28,
        OP_MEM_WRITE_Y = 6'h29,
        OP_MEM_WRITE_Y_INC = 6'h2a
    } fbx_op_t;

    localparam logic [5:0] OP_LAST = 6'h2a;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_MEM = 2'b10
    } fbx_state_t;

    typedef struct packed {
        logic [7:0] imm;
        logic [2:0] bitn;
        logic [4:0] src;
        logic [2:0] rsv_hi;
        logic [4:0] dst;
        logic [1:0] rsv_lo;
        logic [5:0] op;
    } fbx_cmd_t;

    typedef struct packed {
        logic [DMEM_AW-1:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } fbx_dmem_req_t;

    typedef struct packed {
        logic load;
        logic store;
        logic inc;
        logic dec;
        logic disp;
        logic direct;
        logic [4:0] ptr;
    } fbx_memop_t;

    function automatic fbx_memop_t fbx_mem_decode(input logic [5:0] op);
        fbx_memop_t m;
        m.load = (op >= OP_MEM_READ_X) && (op <= OP_MEM_READ_ABSOLUTE);
        m.store = (op >= OP_MEM_WRITE_X) && (op <= OP_LAST);
        m.inc = op inside {OP_MEM_READ_X_INC, OP_MEM_READ_Y_INC,
            OP_MEM_READ_Z_INC, OP_MEM_WRITE_X_INC, OP_MEM_WRITE_Y_INC};
        m.dec = op inside {OP_MEM_READ_X_DEC, OP_MEM_READ_Y_DEC,
            OP_MEM_READ_Z_DEC, OP_MEM_WRITE_X_DEC};
        m.disp = op inside {OP_MEM_READ_OFFSET_Y, OP_MEM_READ_OFFSET_Z};
        m.direct = (op == OP_MEM_READ_ABSOLUTE);
        if (op inside {OP_MEM_READ_X, OP_MEM_READ_X_INC, OP_MEM_READ_X_DEC,
            OP_MEM_WRITE_X, OP_MEM_WRITE_X_INC, OP_MEM_WRITE_X_DEC})
            m.ptr = PTR_X;
        else if (op inside {OP_MEM_READ_Y, OP_MEM_READ_Y_INC,
            OP_MEM_READ_Y_DEC, OP_MEM_READ_OFFSET_Y, OP_MEM_WRITE_Y,
            OP_MEM_WRITE_Y_INC})
            m.ptr = PTR_Y;
        else
            m.ptr = PTR_Z;
        return m;
    endfunction : fbx_mem_decode

    function automatic logic [4:0] fbx_hi(input logic [4:0] lo);
        return {lo[4:1], 1'b1};
    endfunction : fbx_hi

endpackage : fbx_pkg

// ===== core/fbx_bitops.sv
// Single-cycle shift, swap, bit transfer and flag operations
`timescale 1ns/1ns
module fbx_bitops (
    input wire fbx_pkg::fbx_cmd_t cmd,
    input wire logic [7:0] dst_val,
    input wire logic [7:0] src_val,
    input wire logic [7:0] status_register,
    output logic [7:0] res,
    output logic res_we,
    output logic [7:0] status_register_nxt
);

    logic [7:0] shifted;

    assign shifted = {dst_val[7], dst_val[7:1]};

    always_comb
    begin
        res = dst_val;
        res_we = 1'b0;
        status_register_nxt = status_register;
        unique case (cmd.op) inside
            fbx_pkg::OP_ARITH_RIGHT_SHIFT:
            begin
                res = shifted;
                res_we = 1'b1;
                status_register_nxt[fbx_pkg::SB_C] = dst_val[0];
                status_register_nxt[fbx_pkg::SB_N] = shifted[7];
                status_register_nxt[fbx_pkg::SB_Z] = (shifted == 8'h00);
                status_register_nxt[fbx_pkg::SB_V] = shifted[7] ^ dst_val[0];
            end
            fbx_pkg::OP_NIBBLE_SWAP:
            begin
                res = {dst_val[3:0], dst_val[7:4]};
                res_we = 1'b1;
            end
            fbx_pkg::OP_STATUS_BIT_RAISE:
                status_register_nxt[cmd.bitn] = 1'b1;
            fbx_pkg::OP_STATUS_BIT_LOWER:
                status_register_nxt[cmd.bitn] = 1'b0;
            fbx_pkg::OP_BIT_TO_TRANSFER_FLAG:
                status_register_nxt[fbx_pkg::SB_T] = src_val[cmd.bitn];
            fbx_pkg::OP_TRANSFER_FLAG_TO_BIT:
            begin
                res[cmd.bitn] = status_register[fbx_pkg::SB_T];
                res_we = 1'b1;
            end
            // Raise codes are odd, lower codes even, so bit 0 is the value
            [fbx_pkg::OP_CARRY_RAISE:fbx_pkg::OP_CARRY_LOWER]:
                status_register_nxt[fbx_pkg::SB_C] = cmd.op[0];
            [fbx_pkg::OP_NEGATIVE_RAISE:fbx_pkg::OP_NEGATIVE_LOWER]:
                status_register_nxt[fbx_pkg::SB_N] = cmd.op[0];
            [fbx_pkg::OP_ZERO_RAISE:fbx_pkg::OP_ZERO_LOWER]:
                status_register_nxt[fbx_pkg::SB_Z] = cmd.op[0];
            [fbx_pkg::OP_IRQ_GLOBAL_ON:fbx_pkg::OP_IRQ_GLOBAL_OFF]:
                status_register_nxt[fbx_pkg::SB_I] = cmd.op[0];
            [fbx_pkg::OP_SIGN_FLAG_RAISE:fbx_pkg::OP_SIGN_FLAG_LOWER]:
                status_register_nxt[fbx_pkg::SB_S] = cmd.op[0];
            [fbx_pkg::OP_OVERFLOW_RAISE:fbx_pkg::OP_OVERFLOW_LOWER]:
                status_register_nxt[fbx_pkg::SB_V] = cmd.op[0];
            [fbx_pkg::OP_TRANSFER_FLAG_RAISE:fbx_pkg::OP_TRANSFER_FLAG_LOWER]:
                status_register_nxt[fbx_pkg::SB_T] = cmd.op[0];
            [fbx_pkg::OP_HALF_CARRY_RAISE:fbx_pkg::OP_HALF_CARRY_LOWER]:
                status_register_nxt[fbx_pkg::SB_H] = cmd.op[0];
            default:
                res_we = 1'b0;
        endcase
    end

endmodule : fbx_bitops

// ===== core/fbx_core.sv
// Flag, bit transfer and data-memory move core with an APB slave
`timescale 1ns/1ns
// Notes on behaviour
// - Arithmetic right shift keeps bit 7, shifts the rest down, sets Z C N V, one clock.
// - Bit-to-flag copies the chosen source bit into the transfer flag in one clock.
// - Flag-to-bit writes the transfer flag into the chosen bit in one clock, no flags.
// - Overflow raise and lower set or clear only the overflow flag in one clock.
// - Half-carry raise and lower set or clear the half-carry flag in one clock.
// - Sign raise and lower set or clear only the signed test flag in one clock.
// - Pointer loads read memory at the pointer in two clocks, post-inc adds one after.
// - Pre-decrement loads subtract one from the pointer, then read the new address.
// - Offset loads read at the second or third pointer plus a constant, pointer kept.
// - Absolute load reads the address held in the absolute address register in two clocks.
// - Stores via the first pointer write in two clocks, post-inc adds one after.
// - Pre-decrement stores via the first pointer subtract one, then write there.
// - Stores via the second pointer write in two clocks, post-inc adds one after.
// - Pre-decrement load via the second pointer decrements, then reads the new address.
module fbx_core (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [fbx_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output fbx_pkg::fbx_dmem_req_t dmem_req,
    input wire logic [7:0] dmem_rdata
);

    logic [7:0] gpr_r [fbx_pkg::GPR_N];
    logic [7:0] status_register_r;
    fbx_pkg::fbx_cmd_t cmd_r;
    fbx_pkg::fbx_state_t state_r;
    fbx_pkg::fbx_state_t state_nxt;
    fbx_pkg::fbx_dmem_req_t dmem_req_r;
    logic [15:0] abs_addr_r;
    logic [4:0] gpr_sel_r;
    logic illegal_r;
    logic [31:0] prdata_r;
    logic pslverr_r;

    logic busy;
    logic setup;
    logic access;
    logic wr_fire;
    logic hit;
    logic cmd_go;
    fbx_pkg::fbx_cmd_t cmd_in;
    fbx_pkg::fbx_memop_t mi;
    fbx_pkg::fbx_memop_t mx;
    logic [15:0] ptr_in;
    logic [15:0] ptr_ex;
    logic [15:0] req_addr;
    logic [7:0] alu_res;
    logic alu_we;
    logic [7:0] alu_status_register;

    assign busy = (state_r != fbx_pkg::ST_IDLE);
    assign setup = psel & ~penable;
    assign access = psel & penable;
    // Writes wait while a command runs so software never races the core
    assign pready = ~(busy & pwrite);
    assign wr_fire = access & pwrite & pready;
    assign cmd_go = wr_fire & (paddr == fbx_pkg::OFS_CMD);
    assign cmd_in = fbx_pkg::fbx_cmd_t'(pwdata);
    assign prdata = prdata_r;
    assign pslverr = pslverr_r;
    assign dmem_req = dmem_req_r;

    always_comb
    begin
        hit = paddr inside {fbx_pkg::OFS_CMD, fbx_pkg::OFS_ABS_ADDR,
            fbx_pkg::OFS_STATUS, fbx_pkg::OFS_GPR_SEL,
            fbx_pkg::OFS_GPR_DATA, fbx_pkg::OFS_INFO};
    end

    // Address for a memory command is formed as it is accepted
    always_comb
    begin
        mi = fbx_pkg::fbx_mem_decode(cmd_in.op);
        ptr_in = {gpr_r[fbx_pkg::fbx_hi(mi.ptr)], gpr_r[mi.ptr]};
        if (mi.direct)
            req_addr = abs_addr_r;
        else if (mi.disp)
            req_addr = ptr_in + {10'h000, cmd_in.imm[5:0]};
        else if (mi.dec)
            req_addr = ptr_in - 16'h0001;
        else
            req_addr = ptr_in;
    end

    always_comb
    begin
        mx = fbx_pkg::fbx_mem_decode(cmd_r.op);
        ptr_ex = {gpr_r[fbx_pkg::fbx_hi(mx.ptr)], gpr_r[mx.ptr]};
    end

    fbx_bitops u_bitops (
        .cmd(cmd_r),
        .dst_val(gpr_r[cmd_r.dst]),
        .src_val(gpr_r[cmd_r.src]),
        .status_register(status_register_r),
        .res(alu_res),
        .res_we(alu_we),
        .status_register_nxt(alu_status_register)
    );

    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            fbx_pkg::ST_IDLE:
                if (cmd_go)
                    state_nxt = fbx_pkg::ST_EXEC;
            fbx_pkg::ST_EXEC:
                if (mx.load | mx.store)
                    state_nxt = fbx_pkg::ST_MEM;
                else
                    state_nxt = fbx_pkg::ST_IDLE;
            fbx_pkg::ST_MEM:
                state_nxt = fbx_pkg::ST_IDLE;
            default:
                state_nxt = fbx_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            state_r <= fbx_pkg::ST_IDLE;
        else
            state_r <= state_nxt;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            cmd_r <= '0;
        else if (cmd_go)
            cmd_r <= cmd_in;
    end

    // Request is held for the execute cycle; memory answers one cycle later
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            dmem_req_r <= '0;
        else if (cmd_go)
        begin
            dmem_req_r.addr <= req_addr;
            dmem_req_r.wdata <= gpr_r[cmd_in.src];
            dmem_req_r.we <= mi.store;
            dmem_req_r.re <= mi.load;
        end
        else
        begin
            dmem_req_r.we <= 1'b0;
            dmem_req_r.re <= 1'b0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < fbx_pkg::GPR_N; i++)
                gpr_r[i] <= fbx_pkg::GPR_RST;
        end
        else if (state_r == fbx_pkg::ST_EXEC)
        begin
            if (alu_we)
                gpr_r[cmd_r.dst] <= alu_res;
            unique case (cmd_r.op)
                fbx_pkg::OP_REGISTER_COPY:
                    gpr_r[cmd_r.dst] <= gpr_r[cmd_r.src];
                fbx_pkg::OP_REGISTER_PAIR_COPY:
                begin
                    gpr_r[{cmd_r.dst[4:1], 1'b0}] <=
                        gpr_r[{cmd_r.src[4:1], 1'b0}];
                    gpr_r[fbx_pkg::fbx_hi(cmd_r.dst)] <=
                        gpr_r[fbx_pkg::fbx_hi(cmd_r.src)];
                end
                fbx_pkg::OP_IMMEDIATE_LOAD:
                    gpr_r[cmd_r.dst] <= cmd_r.imm;
                default:
                    ;
            endcase
            // Offset and absolute forms leave the pointer alone
            if (mx.inc)
            begin
                gpr_r[mx.ptr] <= 8'(ptr_ex + 16'h0001);
                gpr_r[fbx_pkg::fbx_hi(mx.ptr)] <= 8'((ptr_ex + 16'h0001) >> 8);
            end
            else if (mx.dec)
            begin
                gpr_r[mx.ptr] <= 8'(ptr_ex - 16'h0001);
                gpr_r[fbx_pkg::fbx_hi(mx.ptr)] <= 8'((ptr_ex - 16'h0001) >> 8);
            end
        end
        else if (state_r == fbx_pkg::ST_MEM)
        begin
            // Loaded byte lands last, so it wins over a pointer update
            if (mx.load)
                gpr_r[cmd_r.dst] <= dmem_rdata;
        end
        else if (wr_fire && paddr == fbx_pkg::OFS_GPR_DATA)
            gpr_r[gpr_sel_r] <= pwdata[7:0];
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            status_register_r <= fbx_pkg::STATUS_REGISTER_RST;
        else if (state_r == fbx_pkg::ST_EXEC)
            status_register_r <= alu_status_register;
        else if (wr_fire && paddr == fbx_pkg::OFS_STATUS)
            status_register_r <= pwdata[7:0];
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            abs_addr_r <= fbx_pkg::ABS_ADDR_RST;
            gpr_sel_r <= 5'h00;
        end
        else if (wr_fire)
        begin
            if (paddr == fbx_pkg::OFS_ABS_ADDR)
                abs_addr_r <= pwdata[15:0];
            if (paddr == fbx_pkg::OFS_GPR_SEL)
                gpr_sel_r <= pwdata[4:0];
        end
    end

    // Unknown command codes run as one-clock no-ops and leave a sticky mark
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            illegal_r <= 1'b0;
        else if (cmd_go && cmd_in.op > fbx_pkg::OP_LAST)
            illegal_r <= 1'b1;
        else if (wr_fire && paddr == fbx_pkg::OFS_INFO &&
            pwdata[fbx_pkg::INFO_ILLEGAL_BIT])
            illegal_r <= 1'b0;
    end

    // Read data and error are captured in the setup cycle
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end
        else if (setup)
        begin
            pslverr_r <= ~hit;
            prdata_r <= 32'h0000_0000;
            if (!pwrite)
            begin
                unique case (paddr)
                    fbx_pkg::OFS_CMD:
                        prdata_r <= cmd_r;
                    fbx_pkg::OFS_ABS_ADDR:
                        prdata_r <= {16'h0000, abs_addr_r};
                    fbx_pkg::OFS_STATUS:
                        prdata_r <= {23'h000000, busy, status_register_r};
                    fbx_pkg::OFS_GPR_SEL:
                        prdata_r <= {27'h0000000, gpr_sel_r};
                    fbx_pkg::OFS_GPR_DATA:
                        prdata_r <= {24'h000000, gpr_r[gpr_sel_r]};
                    fbx_pkg::OFS_INFO:
                        prdata_r <= {31'h00000000, illegal_r};
                    default:
                        prdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule : fbx_core

// ===== tb/fbx_core_asserts.sv
// Port-level checker for the flag and memory core
`timescale 1ns/1ns
module fbx_core_asserts (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [fbx_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire fbx_pkg::fbx_dmem_req_t dmem_req,
    input wire logic [7:0] dmem_rdata
);
    logic acc;
    logic mapped;
    logic [5:0] op;
    assign op = pwdata[5:0];
    assign acc = psel && penable && pwrite && pready
        && paddr == fbx_pkg::OFS_CMD;
    assign mapped = paddr[1:0] == 2'b00 && paddr <= fbx_pkg::OFS_INFO;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    mem_pulse_a: assert property ((dmem_req.re || dmem_req.we)
        |=> !(dmem_req.re || dmem_req.we))
        else $error("memory strobe longer than one cycle");
    load_req_a: assert property (acc && op inside {[6'h1a:6'h25]}
        |=> dmem_req.re && !dmem_req.we)
        else $error("load did not issue one read");
    store_req_a: assert property (acc && op inside {[6'h26:6'h2a]}
        |=> dmem_req.we && !dmem_req.re)
        else $error("store did not issue one write");
    no_mem_a: assert property (acc && !(op inside {[6'h1a:6'h2a]})
        |=> !dmem_req.we && !dmem_req.re)
        else $error("register op touched memory");
    read_fast_a: assert property (psel && penable && !pwrite |-> pready)
        else $error("read was stalled");
    write_wait_a: assert property (psel && penable && pwrite && !pready
        |-> ##[1:3] pready)
        else $error("write stall too long");
    bad_addr_a: assert property (psel && !penable && !mapped
        |=> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not flagged");
    good_addr_a: assert property (psel && !penable && mapped |=> !pslverr)
        else $error("mapped access flagged");
    addr_hold_a: assert property ($changed(dmem_req.addr) |-> $past(acc))
        else $error("memory address moved without a command");
endmodule : fbx_core_asserts

bind fbx_core fbx_core_asserts i_chk (.clock(clock), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dmem_req(dmem_req), .dmem_rdata(dmem_rdata));

// ===== tb/fbx_mem_model.sv
// Data memory model with one cycle read latency
`timescale 1ns/1ns
module fbx_mem_model (
    input wire logic clock,
    input wire fbx_pkg::fbx_dmem_req_t dmem_req,
    output logic [7:0] dmem_rdata
);
    logic [7:0] mem [int];
    logic [23:0] wr_log [$];
    initial dmem_rdata = 8'h00;
    always @(posedge clock)
    begin
        if (dmem_req.re)
            dmem_rdata <= mem.exists(int'(dmem_req.addr)) ?
                mem[int'(dmem_req.addr)] :
                dmem_req.addr[7:0] ^ dmem_req.addr[15:8] ^ 8'h5a;
        else
            // Toggle outside reads so stale data can never pass
            dmem_rdata <= ~dmem_rdata;
        if (dmem_req.we)
        begin
            mem[int'(dmem_req.addr)] = dmem_req.wdata;
            wr_log.push_back({dmem_req.addr, dmem_req.wdata});
        end
    end
endmodule : fbx_mem_model

// ===== tb/tb_flag_bit_and_load_store_exec.sv
// Self-checking bench for the flag and memory core
`timescale 1ns/1ns
module tb_flag_bit_and_load_store_exec;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    fbx_pkg::fbx_dmem_req_t dmem_req;
    logic [7:0] dmem_rdata;
    int fail_count = 0;
    int comparisons = 0;
    int seed = 32'h0e40094e;
    logic [7:0] gpr [32];
    logic [7:0] flags_m = 8'h00;
    logic [15:0] abs_a = 16'h0000;
    logic bad_op = 1'b0;
    logic [7:0] mem [int];
    logic [23:0] exp_wr [$];
    logic [31:0] q;
    logic [31:0] c;
    logic e;
    int fl [8] = '{0, 2, 1, 7, 4, 3, 6, 5};

    fbx_core i_dut (.clock(clock), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .dmem_req(dmem_req), .dmem_rdata(dmem_rdata));
    fbx_mem_model i_mem (.clock(clock), .dmem_req(dmem_req),
        .dmem_rdata(dmem_rdata));

    initial forever #4 clock = ~clock;

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Values are taken at the edge where pready is seen high
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        logic r;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do
        begin
            @(posedge clock);
            r = pready;
            q = prdata;
            e = pslverr;
        end while (r !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask : apb

    function automatic logic [7:0] rd(input logic [15:0] a);
        return mem.exists(int'(a)) ? mem[int'(a)] : a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction : rd

    task automatic model(input logic [31:0] w);
        logic [5:0] op;
        logic [4:0] d;
        logic [4:0] s;
        logic [4:0] pi;
        logic [2:0] b;
        logic [7:0] k;
        logic [7:0] v;
        logic [15:0] p;
        logic [15:0] a;
        op = w[5:0];
        d = w[12:8];
        s = w[20:16];
        b = w[23:21];
        k = w[31:24];
        v = gpr[d];
        case (op) inside
            6'h01:
            begin
                gpr[d] = {v[7], v[7:1]};
                flags_m[3:0] = {v[7] ^ v[0], v[7], gpr[d] == 8'h00, v[0]};
            end
            6'h02: gpr[d] = {v[3:0], v[7:4]};
            6'h03, 6'h04: flags_m[b] = op[0];
            6'h05: flags_m[6] = gpr[s][b];
            6'h06: gpr[d][b] = flags_m[6];
            [6'h07:6'h16]: flags_m[fl[(op - 7) / 2]] = op[0];
            6'h17: gpr[d] = gpr[s];
            6'h18:
            begin
                v = gpr[{s[4:1], 1'b1}];
                gpr[{d[4:1], 1'b0}] = gpr[{s[4:1], 1'b0}];
                gpr[{d[4:1], 1'b1}] = v;
            end
            6'h19: gpr[d] = k;
            [6'h1a:6'h2a]:
            begin
                pi = op inside {[6'h1a:6'h1c], [6'h26:6'h28]} ?
                    fbx_pkg::PTR_X : op inside {[6'h1d:6'h20], 6'h29, 6'h2a} ?
                    fbx_pkg::PTR_Y : fbx_pkg::PTR_Z;
                p = {gpr[pi + 5'd1], gpr[pi]};
                a = p;
                if (op inside {6'h1c, 6'h1f, 6'h23, 6'h28})
                begin
                    a = p - 16'h0001;
                    p = a;
                end
                if (op inside {6'h1b, 6'h1e, 6'h22, 6'h27, 6'h2a})
                    p = p + 16'h0001;
                if (op inside {6'h20, 6'h24})
                    a = p + {10'h000, k[5:0]};
                if (op == 6'h25)
                    a = abs_a;
                if (op >= 6'h26)
                begin
                    exp_wr.push_back({a, gpr[s]});
                    mem[int'(a)] = gpr[s];
                end
                {gpr[pi + 5'd1], gpr[pi]} = p;
                if (op < 6'h26)
                    gpr[d] = rd(a);
            end
            default: bad_op = bad_op | (op > 6'h2a);
        endcase
    endtask : model

    task automatic check_all();
        int n;
        n = 0;
        do
        begin
            apb(1'b0, fbx_pkg::OFS_STATUS, 32'h0);
            n++;
        end while (q[8] !== 1'b0 && n < 20);
        chk(q, {24'h0, flags_m});
        for (int k = 0; k < 32; k++)
        begin
            apb(1'b1, fbx_pkg::OFS_GPR_SEL, k);
            apb(1'b0, fbx_pkg::OFS_GPR_DATA, 32'h0);
            chk(q, {24'h0, gpr[k]});
        end
        while (exp_wr.size() > 0)
        begin
            chk(i_mem.wr_log.size() > 0 ? i_mem.wr_log.pop_front() : 'x,
                exp_wr.pop_front());
        end
        chk(i_mem.wr_log.size(), 0);
    endtask : check_all

    initial
    begin
        repeat (60000) @(posedge clock);
        fail_count++;
        $display("watchdog expired");
        wrap_up();
    end

    initial
    begin
        for (int k = 0; k < 32; k++)
            gpr[k] = 8'h00;
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        check_all();
        apb(1'b0, fbx_pkg::OFS_INFO, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, 8'h18, 32'h0);
        chk({q[30:0], e}, 32'h1);
        apb(1'b1, 8'h1c, 32'hffff_ffff);
        chk({31'h0, e}, 32'h1);
        $display("test reset and unmapped done");
        for (int k = 0; k < 32; k++)
        begin
            gpr[k] = $random(seed);
            apb(1'b1, fbx_pkg::OFS_GPR_SEL, k);
            apb(1'b1, fbx_pkg::OFS_GPR_DATA, {24'h0, gpr[k]});
        end
        for (int i = 0; i < 160; i++)
        begin
            if (i % 8 == 0)
            begin
                abs_a = $random(seed);
                flags_m = $random(seed);
                apb(1'b1, fbx_pkg::OFS_ABS_ADDR, {16'h0, abs_a});
                apb(1'b1, fbx_pkg::OFS_STATUS, {24'h0, flags_m});
            end
            c = $random(seed);
            c[7:6] = 2'b00;
            c[15:13] = 3'b000;
            c[5:0] = i < 48 ? i : c[5:0] % 48;
            // Two commands back to back: the core is idle again by the second access, so no stall
            apb(1'b1, fbx_pkg::OFS_CMD, c);
            model(c);
            if (i % 2 == 1)
                check_all();
        end
        $display("test command sweep done");
        apb(1'b0, fbx_pkg::OFS_INFO, 32'h0);
        chk(q, {31'h0, bad_op});
        apb(1'b1, fbx_pkg::OFS_INFO, 32'h1);
        apb(1'b0, fbx_pkg::OFS_INFO, 32'h0);
        chk(q, 32'h0);
        $display("test illegal flag done");
        wrap_up();
    end
endmodule : tb_flag_bit_and_load_store_exec
